// file: sewp_pkg.sv
// Behaviour
// - data line changes only while clock is low; high-clock changes are start or stop
// - falling data with clock high is a start and begins a new transfer
// - rising data with clock high is a stop and ends the transfer
// - a stop that ends a read puts the device into standby
// - words are 8 bits; device pulls data low in the ninth clock to acknowledge
// - standby at power-up and after stop once internal work ends, sensor disabled
// - upper address nibble 1010 array, 0110 protect register, 0011 temperature sensor
// - next three bits must match address pins, else no acknowledge and standby
// - lowest address bit selects direction: one read, zero write
// - once permanent protection is programmed, code 0110 is not acknowledged
// - byte write is address word, word address, one data byte, then stop
// - stop after a write starts a timed cycle of at most 5 ms; bus ignored
// - protected writes are acknowledged but leave protected data unchanged
// - page write carries up to 16 bytes, each acknowledged, ended by stop
// - only the low four word-address bits increment and wrap within the page
// - array holds 256 bytes as 16 pages of 16, 8-bit word address
// - during the write cycle address polls get an acknowledge only when done
// - with timeout enabled for sensor traffic, long clock-low resets the interface
// - software protection covers only word addresses 00h to 7fh
package sewp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ               = 40_000_000;
  localparam int WRITE_CYCLE_TIME_MS  = 5;
  // longest time: rounds down
  localparam int WRITE_CYCLE_CYC      = WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);
  localparam int BUS_TIMEOUT_TIME_MS  = 25;
  // least time: whole milliseconds, exact
  localparam int BUS_TIMEOUT_CYC      = BUS_TIMEOUT_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // array and word layout
  // ----------------------------------------------------------------
  localparam int         WORD_BITS    = 8;
  localparam int         MEM_BYTES    = 256;
  localparam int         PAGE_BYTES   = 16;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [1:0] IDX_DEV      = 2'h0;
  localparam logic [1:0] IDX_WORD     = 2'h1;
  localparam logic [1:0] IDX_DATA     = 2'h2;
  localparam logic [7:0] PROTECT_TOP  = 8'h7f;
  localparam logic [4:0] SYNC_RST     = 5'h1f;

  // ----------------------------------------------------------------
  // device address codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_ARRAY   = 4'ha;
  localparam logic [3:0] CODE_PROTECT = 4'h6;
  localparam logic [3:0] CODE_SENSOR  = 4'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX   = 4'b0010,
    ST_ACK  = 4'b0100,
    ST_HOLD = 4'b1000
  } sewp_state_e;

  typedef enum logic [1:0] {
    TGT_NONE    = 2'h0,
    TGT_ARRAY   = 2'h1,
    TGT_PROTECT = 2'h2,
    TGT_SENSOR  = 2'h3
  } sewp_tgt_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } sewp_bus_ev_s;

  // low nibble steps and wraps, page row stays
  function automatic logic [7:0] sewp_page_next(input logic [7:0] a);
    return {a[7:4], 4'(a[3:0] + 4'h1)};
  endfunction

endpackage

// file: sewp_sync.sv
`timescale 1ns/1ps
module sewp_sync #(
  parameter int         W       = 5,
  parameter logic [4:0] RST_VAL = 5'h1f
) (
  input  wire logic         i_clk_sys,  // system clock
  input  wire logic         i_rst_b,    // sync reset, active low
  input  wire logic [W-1:0] i_d,        // asynchronous pins
  output logic      [W-1:0] o_q,        // synchronised level
  output logic      [W-1:0] o_q_dly     // level one cycle older
);

  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // two-flop synchroniser plus one stage for edge finding
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      meta    <= RST_VAL[W-1:0];
      o_q     <= RST_VAL[W-1:0];
      o_q_dly <= RST_VAL[W-1:0];
    end else begin
      meta    <= i_d;
      o_q     <= meta;
      o_q_dly <= o_q;
    end
  end

endmodule

// file: sewp_wr_timer.sv
`timescale 1ns/1ps
module sewp_wr_timer #(
  parameter int CYC = sewp_pkg::WRITE_CYCLE_CYC
) (
  input  wire logic i_clk_sys,  // system clock
  input  wire logic i_rst_b,    // sync reset, active low
  input  wire logic i_start,    // one-cycle start of a write cycle
  output logic      o_busy      // high while the write cycle runs
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt;

  // ----------------------------------------------------------------
  // self-timed write cycle counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      cnt    <= '0;
      o_busy <= 1'b0;
    end else if (i_start && !o_busy) begin
      cnt    <= CW'(CYC - 1);
      o_busy <= 1'b1;
    end else if (o_busy) begin
      cnt    <= cnt - CW'(1);
      o_busy <= (cnt != '0);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CW-1:0] len;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !o_busy) begin
      len <= '0;
    end else begin
      len <= len + CW'(1);
    end
  end

  property p_cycle_len;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      $fell(o_busy) |-> ($past(len) == CW'(CYC - 1));
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("write cycle length differs from its count");

  property p_cycle_start;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_start && !o_busy) |=> o_busy [*2];
  endproperty
  a_cycle_start: assert property (p_cycle_start)
    else $error("write cycle did not start on request");

endmodule

// file: sewp_write_path.sv
`timescale 1ns/1ps
module sewp_write_path #(
  parameter int WR_CYC   = sewp_pkg::WRITE_CYCLE_CYC,
  parameter int BUS_TIMEOUT_TIME_CYC = sewp_pkg::BUS_TIMEOUT_CYC
) (
  input  wire logic       i_clk_sys,    // system clock, 40 mhz
  input  wire logic       i_rst_b,      // sync reset, active low
  input  wire logic       i_scl,        // serial clock pin
  input  wire logic       i_sda,        // serial data pin, input side
  output logic            o_sda_out,    // serial data drive value, always 0
  output logic            o_sda_oe_b,   // serial data enable, low drives
  input  wire logic [2:0] i_addr_sel,   // address_select_pin_2..0
  input  wire logic       i_wp_rev,     // reversible protection active
  input  wire logic       i_timeout_en, // bus timeout on sensor traffic
  input  wire logic       i_sensor_en,  // temperature sensor running
  input  wire logic [7:0] i_mem_addr,   // array inspection address
  output logic      [7:0] o_mem_data,   // array byte at that address
  output logic            o_wp_perm,    // permanent protection set
  output logic            o_busy,       // write cycle running
  output logic            o_standby     // low-power standby
);

  localparam int TW = $clog2(BUS_TIMEOUT_TIME_CYC + 1);
  // ----------------------------------------------------------------
  // pin sampling and bus events
  // ----------------------------------------------------------------
  logic [4:0]            sync_q;
  logic [4:0]            sync_dly;
  sewp_pkg::sewp_bus_ev_s ev;
  logic [2:0]            pins;

  sewp_sync #(
    .W       (5),
    .RST_VAL (sewp_pkg::SYNC_RST)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_d       ({i_addr_sel, i_sda, i_scl}),
    .o_q       (sync_q),
    .o_q_dly   (sync_dly)
  );

  always_comb begin
    pins        = sync_q[4:2];
    ev.scl      = sync_q[0];
    ev.sda      = sync_q[1];
    ev.scl_rise = sync_q[0] & ~sync_dly[0];
    ev.scl_fall = ~sync_q[0] & sync_dly[0];
    // data moving while clock stays high is a bus condition
    ev.start    = sync_q[0] & sync_dly[0] & sync_dly[1] & ~sync_q[1];
    ev.stop     = sync_q[0] & sync_dly[0] & ~sync_dly[1] & sync_q[1];
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sewp_pkg::sewp_state_e state;
  sewp_pkg::sewp_state_e next_state;
  sewp_pkg::sewp_tgt_e   tgt;
  sewp_pkg::sewp_tgt_e   next_tgt;
  logic [3:0]            bit_cnt;
  logic [1:0]            byte_idx;
  logic [7:0]            shift;
  logic [7:0]            nb;
  logic                  is_read;
  logic                  ack_ok;
  logic                  rx_last;
  logic                  dev_ok;
  logic                  ack_now;
  logic                  timeout_hit;
  logic                  bus_timeout_time_run;
  logic [TW-1:0]         bus_timeout_time_cnt;
  logic [7:0]            word_addr;
  logic [7:0]            page_buf [sewp_pkg::PAGE_BYTES];
  logic [15:0]           page_mask;
  logic                  pend_wr;
  logic                  pend_wp;
  logic                  commit;
  logic                  wp_active;
  logic [7:0]            mem [sewp_pkg::MEM_BYTES];

  // byte decode
  always_comb begin
    nb       = {shift[6:0], ev.sda};
    rx_last  = (state == sewp_pkg::ST_RX) && ev.scl_rise &&
               (bit_cnt == sewp_pkg::BIT_LAST);
    next_tgt = sewp_pkg::TGT_NONE;
    case (nb[7:4])
      sewp_pkg::CODE_ARRAY:   next_tgt = sewp_pkg::TGT_ARRAY;
      sewp_pkg::CODE_PROTECT: next_tgt = sewp_pkg::TGT_PROTECT;
      sewp_pkg::CODE_SENSOR:  next_tgt = sewp_pkg::TGT_SENSOR;
      default:                next_tgt = sewp_pkg::TGT_NONE;
    endcase
    // inputs ignored while the write cycle runs, so polls go unanswered
    dev_ok = !o_busy && (nb[3:1] == pins) &&
             (next_tgt != sewp_pkg::TGT_NONE) &&
             !(next_tgt == sewp_pkg::TGT_PROTECT &&
               (o_wp_perm || nb[0]));
    if (byte_idx == sewp_pkg::IDX_DEV) begin
      ack_now = dev_ok;
    end else begin
      ack_now = (tgt != sewp_pkg::TGT_NONE) && !is_read;
    end
  end

  // ----------------------------------------------------------------
  // control state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (timeout_hit) begin
      next_state = sewp_pkg::ST_IDLE;
    end else if (ev.start) begin
      next_state = sewp_pkg::ST_RX;
    end else if (ev.stop) begin
      next_state = sewp_pkg::ST_IDLE;
    end else begin
      case (state)
        sewp_pkg::ST_RX: begin
          if (ev.scl_fall && bit_cnt == sewp_pkg::BIT_ACK) begin
            next_state = ack_ok ? sewp_pkg::ST_ACK : sewp_pkg::ST_IDLE;
          end
        end
        sewp_pkg::ST_ACK: begin
          if (ev.scl_fall) begin
            // read data path lives elsewhere; release after address
            next_state = is_read ? sewp_pkg::ST_HOLD : sewp_pkg::ST_RX;
          end
        end
        sewp_pkg::ST_HOLD: next_state = sewp_pkg::ST_HOLD;
        default:           next_state = sewp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state <= sewp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // bit and byte counters, shift register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || ev.start || next_state == sewp_pkg::ST_IDLE) begin
      bit_cnt  <= 4'h0;
      byte_idx <= sewp_pkg::IDX_DEV;
      shift    <= 8'h00;
    end else if (state == sewp_pkg::ST_RX && ev.scl_rise &&
                 bit_cnt != sewp_pkg::BIT_ACK) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift   <= nb;
    end else if (state == sewp_pkg::ST_ACK && ev.scl_fall) begin
      bit_cnt <= 4'h0;
      if (byte_idx != sewp_pkg::IDX_DATA) begin
        byte_idx <= byte_idx + 2'h1;
      end
    end
  end

  // address word capture
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || ev.start) begin
      tgt     <= sewp_pkg::TGT_NONE;
      is_read <= 1'b0;
      ack_ok  <= 1'b0;
    end else if (rx_last) begin
      ack_ok <= ack_now;
      if (byte_idx == sewp_pkg::IDX_DEV && dev_ok) begin
        tgt     <= next_tgt;
        is_read <= nb[0];
      end
    end
  end

  // acknowledge drive: low through the ninth clock
  assign o_sda_out = 1'b0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_sda_oe_b <= 1'b1;
    end else begin
      o_sda_oe_b <= (next_state != sewp_pkg::ST_ACK);
    end
  end

  // ----------------------------------------------------------------
  // word address and page buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      word_addr <= 8'h00;
      page_mask <= 16'h0000;
      pend_wr   <= 1'b0;
      pend_wp   <= 1'b0;
    end else if (ev.start || ev.stop) begin
      page_mask <= 16'h0000;
      pend_wr   <= 1'b0;
      pend_wp   <= 1'b0;
    end else if (rx_last && ack_now && byte_idx != sewp_pkg::IDX_DEV) begin
      if (tgt == sewp_pkg::TGT_ARRAY && byte_idx == sewp_pkg::IDX_WORD) begin
        word_addr <= nb;
      end else if (tgt == sewp_pkg::TGT_ARRAY) begin
        page_buf[word_addr[3:0]]  <= nb;
        page_mask[word_addr[3:0]] <= 1'b1;
        word_addr <= sewp_pkg::sewp_page_next(word_addr);
        pend_wr   <= 1'b1;
      end else if (tgt == sewp_pkg::TGT_PROTECT &&
                   byte_idx == sewp_pkg::IDX_DATA) begin
        pend_wp <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // write cycle and commit
  // ----------------------------------------------------------------
  assign commit    = ev.stop && !o_busy && (pend_wr || pend_wp);
  assign wp_active = o_wp_perm || i_wp_rev;

  sewp_wr_timer #(
    .CYC (WR_CYC)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_start   (commit),
    .o_busy    (o_busy)
  );

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_wp_perm <= 1'b0;
    end else if (commit && pend_wp) begin
      o_wp_perm <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (commit && pend_wr) begin
      for (int i = 0; i < sewp_pkg::PAGE_BYTES; i++) begin
        // protected low half keeps its data though the write was acked
        if (page_mask[i] &&
            !(wp_active &&
              {word_addr[7:4], 4'(i)} <= sewp_pkg::PROTECT_TOP)) begin
          mem[{word_addr[7:4], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_mem_data <= 8'h00;
    end else begin
      o_mem_data <= mem[i_mem_addr];
    end
  end

  // bus timeout on sensor traffic
  assign bus_timeout_time_run    = i_timeout_en && !ev.scl &&
                       (tgt == sewp_pkg::TGT_SENSOR) &&
                       (state != sewp_pkg::ST_IDLE);
  assign timeout_hit = bus_timeout_time_run && (bus_timeout_time_cnt == TW'(BUS_TIMEOUT_TIME_CYC - 1));

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b || !bus_timeout_time_run) begin
      bus_timeout_time_cnt <= '0;
    end else if (!timeout_hit) begin
      bus_timeout_time_cnt <= bus_timeout_time_cnt + TW'(1);
    end
  end

  // standby
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_standby <= 1'b1;
    end else begin
      o_standby <= (next_state == sewp_pkg::ST_IDLE) && !o_busy &&
                   !commit && !i_sensor_en;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_addr_word_done;
    rx_last && (byte_idx == sewp_pkg::IDX_DEV);
  endsequence

  property p_start_restart;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (ev.start && !timeout_hit) |=>
        (state == sewp_pkg::ST_RX) && (bit_cnt == 4'h0) &&
        (byte_idx == sewp_pkg::IDX_DEV);
  endproperty
  a_start_restart: assert property (p_start_restart)
    else $error("start did not begin a new transfer");
  property p_stop_idle;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ev.stop && !ev.start |=> (state == sewp_pkg::ST_IDLE) && o_sda_oe_b;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not end the transfer");
  property p_ack_on_fall;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      $fell(o_sda_oe_b) |-> $past(ev.scl_fall) &&
                            ($past(bit_cnt) == sewp_pkg::BIT_ACK);
  endproperty
  a_ack_on_fall: assert property (p_ack_on_fall)
    else $error("acknowledge not started after eighth bit");
  property p_busy_silent;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      o_busy && $past(o_busy) |-> o_sda_oe_b;
  endproperty
  a_busy_silent: assert property (p_busy_silent)
    else $error("bus answered during the write cycle");
  property p_poll_nack;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (s_addr_word_done and o_busy) |=> !ack_ok;
  endproperty
  a_poll_nack: assert property (p_poll_nack)
    else $error("poll acknowledged during write cycle");
  property p_pin_mismatch;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (s_addr_word_done and (nb[3:1] != pins)) |=> !ack_ok;
  endproperty
  a_pin_mismatch: assert property (p_pin_mismatch)
    else $error("address with wrong pins acknowledged");
  property p_protect_locked;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (s_addr_word_done and o_wp_perm and
       (nb[7:4] == sewp_pkg::CODE_PROTECT)) |=> !ack_ok;
  endproperty
  a_protect_locked: assert property (p_protect_locked)
    else $error("protect code acknowledged after locking");
  property p_page_wrap;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (rx_last && ack_now && tgt == sewp_pkg::TGT_ARRAY &&
       byte_idx == sewp_pkg::IDX_DATA && !ev.start && !ev.stop) |=>
        (word_addr[7:4] == $past(word_addr[7:4])) &&
        (word_addr[3:0] == 4'($past(word_addr[3:0]) + 4'h1));
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("word address left its page");
  property p_write_timed;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      commit |=> o_busy ##1 o_busy;
  endproperty
  a_write_timed: assert property (p_write_timed)
    else $error("write cycle not started after stop");
  property p_timeout_reset;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      timeout_hit |=> (state == sewp_pkg::ST_IDLE) && o_sda_oe_b;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("bus timeout did not reset the interface");
  property p_standby;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      (state == sewp_pkg::ST_IDLE) && !o_busy && !i_sensor_en &&
      !ev.start && !commit ##1 !ev.start && !o_busy |-> o_standby;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not entered while idle");

endmodule

// file: sewp_master.sv
`timescale 1ns/1ps
module sewp_master (
  input  wire logic i_clk_sys,  // bench clock
  input  wire logic i_sda,      // resolved data line
  output logic      o_scl,      // serial clock
  output logic      o_sda       // data drive, 1 = released
);
  // ---------------------------------------------
  // bus cycles: scl low 5 clk, high 3 clk, 200 ns
  // ---------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic start();
    o_sda <= 1'b0;
    cyc(3);
    o_scl <= 1'b0;
    cyc(2);
  endtask
  task automatic stop();
    o_sda <= 1'b0;
    cyc(3);
    o_scl <= 1'b1;
    cyc(3);
    o_sda <= 1'b1;
    cyc(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda <= b;
    cyc(3);
    o_scl <= 1'b1;
    cyc(2);
    r = i_sda;
    cyc(1);
    o_scl <= 1'b0;
    cyc(2);
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recover();
    logic r;
    start();
    repeat (9) bit_io(1'b1, r);
    o_sda <= 1'b1;
    o_scl <= 1'b1;
    cyc(4);
    start();
    o_scl <= 1'b1;
    cyc(3);
    o_sda <= 1'b1;
    cyc(4);
  endtask
endmodule

// file: serial_eeprom_bus_write_path_tb_top.sv
`timescale 1ns/1ps
module serial_eeprom_bus_write_path_tb_top;
  logic       i_clk_sys = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic       wp_rev    = 1'b0;
  logic [2:0] addr_sel  = 3'h5;
  logic       bus_timeout_time_en   = 1'b0;
  logic       sens_en   = 1'b0;
  logic [7:0] mem_addr  = 8'h00;
  logic [7:0] mem_data;
  logic       scl, m_sda, oe_b, sda_out, wp_perm, busy, standby, a;
  wire        sda = m_sda & (oe_b | sda_out);
  int         fails = 0;
  int         compares = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  sewp_master M (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl),
                 .o_sda(m_sda));
  sewp_write_path #(.WR_CYC(400), .BUS_TIMEOUT_TIME_CYC(100)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_b(oe_b), .i_addr_sel(addr_sel),
    .i_wp_rev(wp_rev), .i_timeout_en(bus_timeout_time_en), .i_sensor_en(sens_en),
    .i_mem_addr(mem_addr), .o_mem_data(mem_data), .o_wp_perm(wp_perm),
    .o_busy(busy), .o_standby(standby));
  // ---------------------------------------------
  // shared checks and transfers
  // ---------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    M.tx_byte(b, a);
    chk(8'(a), 8'(exp_ack));
  endtask
  task automatic wait_done();
    int n = 0;
    while (busy !== 1'b0 && n < 600) begin
      @(posedge i_clk_sys);
      n++;
    end
    M.cyc(2);
    chk(8'(busy), 8'h00);
    chk(8'(standby), 8'h01);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    mem_addr <= ad;
    M.cyc(3);
    chk(mem_data, e);
  endtask
  task automatic wr1(input logic [7:0] dev, ad, d);
    M.start();
    send(dev, 1'b1);
    send(ad, 1'b1);
    send(d, 1'b1);
    M.stop();
    M.cyc(4);
    chk(8'(busy), 8'h01);
    chk(8'(standby), 8'h00);
    M.start();
    send(8'haa, 1'b0);
    M.stop();
    wait_done();
  endtask
  task automatic refuse(input logic [7:0] dev);
    M.start();
    send(dev, 1'b0);
    M.stop();
    chk(8'(standby), 8'h01);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset();
    chk({oe_b, busy, standby, wp_perm}, 8'h0a);
    M.recover();
    wr1(8'haa, 8'h10, 8'h3c);
    rd(8'h10, 8'h3c);
    $display("test reset and byte write done");
  endtask
  task automatic t_page();
    M.start();
    send(8'haa, 1'b1);
    send(8'h90, 1'b1);
    for (int i = 0; i < 17; i++) send(8'(8'h40 + i), 1'b1);
    M.stop();
    wait_done();
    rd(8'h90, 8'h50);
    rd(8'h91, 8'h41);
    rd(8'h9f, 8'h4f);
    $display("test page wrap done");
  endtask
  task automatic t_prot();
    refuse(8'ha8);
    refuse(8'h5a);
    wp_rev <= 1'b1;
    wr1(8'haa, 8'h10, 8'h77);
    rd(8'h10, 8'h3c);
    wr1(8'haa, 8'h80, 8'h66);
    rd(8'h80, 8'h66);
    wp_rev <= 1'b0;
    wr1(8'h6a, 8'h00, 8'h00);
    chk(8'(wp_perm), 8'h01);
    refuse(8'h6a);
    wr1(8'haa, 8'h10, 8'h55);
    rd(8'h10, 8'h3c);
    $display("test protection done");
  endtask
  task automatic t_misc();
    addr_sel <= 3'h2;
    M.cyc(4);
    refuse(8'haa);
    M.start();
    send(8'ha4, 1'b1);
    M.stop();
    addr_sel <= 3'h5;
    M.start();
    send(8'hab, 1'b1);
    send(8'hff, 1'b0);
    M.stop();
    chk(8'(standby), 8'h01);
    sens_en <= 1'b1;
    M.start();
    send(8'h3a, 1'b1);
    send(8'h00, 1'b1);
    M.stop();
    chk(8'(standby), 8'h00);
    sens_en <= 1'b0;
    bus_timeout_time_en <= 1'b1;
    M.start();
    send(8'h3a, 1'b1);
    M.cyc(110);
    send(8'h00, 1'b0);
    M.stop();
    bus_timeout_time_en <= 1'b0;
    chk(8'(standby), 8'h01);
    $display("test pins, read, sensor and timeout done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    M.cyc(4);
    t_reset();
    t_page();
    t_prot();
    t_misc();
    close_out();
  end
  initial begin
    // tests take about 0.2 ms; five times that means a hang
    #1_000_000;
    fails++;
    close_out();
  end
endmodule
